// [msaf_chk_props.sv]
`timescale 1ns/1ns
module msaf_chk
(
  input wire logic                 CLK_SYS,
  input wire logic                 RSTN,
  input wire msaf_pkg::msaf_addr_t ADDR,
  input wire msaf_pkg::msaf_byte_t WDATA,
  input wire logic                 WR,
  input wire logic                 RD,
  input wire logic [7:0]           RDATA,
  input wire logic                 IRQ,
  input wire logic                 EV_RX_ALIGN,
  input wire logic                 EV_COLLISION,
  input wire logic                 ADDR_DONE,
  input wire logic [5:0]           HASH_INDEX
);
  import msaf_pkg::*;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // Reads sit two cycles apart, so both cycles must be free of new counts
  sequence tally_twice;
    RD && ADDR == 5'h02 && !EV_RX_ALIGN ##1 !EV_RX_ALIGN ##1 RD && ADDR == 5'h02;
  endsequence
  sequence go_then_retry;
    WR && ADDR == 5'h07 && WDATA[2] && !EV_COLLISION ##1 !EV_COLLISION ##1
      RD && ADDR == 5'h05;
  endsequence
  AST_W0_KEEP: assert property (IRQ && WR && ADDR == 5'h00 && WDATA == 8'h00 |=> IRQ)
    else $error("zero write cleared a flag");
  AST_IRQ_HOLD: assert property (IRQ && !(WR && ADDR inside {5'h00, 5'h01}) |=> IRQ)
    else $error("irq dropped without a clear");
  AST_MASK_OFF: assert property (WR && ADDR == 5'h01 && WDATA == 8'h00 |=> !IRQ)
    else $error("irq with empty mask");
  AST_RST_NOIRQ: assert property (WR && ADDR == 5'h01 && WDATA == 8'h80 |=> !IRQ)
    else $error("bit 7 raised irq");
  AST_TALLY_CAP: assert property ($past(RD) && $past(ADDR) inside {5'h02, 5'h03, 5'h04}
    |-> RDATA <= 8'hc0)
    else $error("tally above cap");
  AST_TALLY_CLR: assert property (tally_twice |=> RDATA == 8'h00)
    else $error("tally not cleared by read");
  AST_RETRY_HI: assert property ($past(RD) && $past(ADDR) == 5'h05 |-> RDATA[7:4] == 4'h0)
    else $error("retry upper bits set");
  AST_GO_CLR: assert property (go_then_retry |=> RDATA == 8'h00)
    else $error("retry not cleared by go");
  AST_HASH_HOLD: assert property (!ADDR_DONE && $past(RSTN) |-> $stable(HASH_INDEX))
    else $error("hash index moved");
endmodule
bind msaf_top msaf_chk u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .EV_RX_ALIGN(EV_RX_ALIGN),
  .EV_COLLISION(EV_COLLISION), .ADDR_DONE(ADDR_DONE), .HASH_INDEX(HASH_INDEX));

// [msaf_da_src.sv]
`timescale 1ns/1ns
module msaf_da_src
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic [47:0] da,
  output logic             start,
  output logic             bit_valid,
  output logic             da_bit
);
  logic [5:0] cnt_q;
  always_ff @(posedge clk)
  begin
    start <= go;
    bit_valid <= 1'b0;
    // Idle line toggles so a stale bit can never pass as data
    da_bit <= ~da_bit;
    if (!rst_n)
    begin
      cnt_q <= 6'h30;
      da_bit <= 1'b0;
    end
    else if (go)
      cnt_q <= 6'h00;
    else if (cnt_q != 6'h30)
    begin
      bit_valid <= 1'b1;
      da_bit <= da[cnt_q];
      cnt_q <= cnt_q + 6'h01;
    end
  end
endmodule

// [msaf_defines.svh]
`ifndef MSAF_DEFINES_SVH
`define MSAF_DEFINES_SVH

// Register offsets on the plain register port (byte index)
`define MSAF_ADDR_ISR       5'h00
`define MSAF_ADDR_IMR       5'h01
`define MSAF_ADDR_TALLY_FAE 5'h02
`define MSAF_ADDR_TALLY_CRC 5'h03
`define MSAF_ADDR_TALLY_MIS 5'h04
`define MSAF_ADDR_RETRY     5'h05
`define MSAF_ADDR_LOOPBACK  5'h06
`define MSAF_ADDR_CMD       5'h07
`define MSAF_ADDR_TSR       5'h08
`define MSAF_ADDR_STATION   5'h10
`define MSAF_ADDR_HASH      5'h18

// Status bit positions
`define MSAF_ISR_PRX 0
`define MSAF_ISR_PTX 1
`define MSAF_ISR_RXE 2
`define MSAF_ISR_TXE 3
`define MSAF_ISR_OVW 4
`define MSAF_ISR_CNT 5
`define MSAF_ISR_RDC 6
`define MSAF_ISR_RST 7

// Command register bits
`define MSAF_CMD_STOP  0
`define MSAF_CMD_START 1
`define MSAF_CMD_TXGO  2
`define MSAF_CMD_LOOP  3

`define MSAF_TSR_ABT 3

`define MSAF_TALLY_MAX 8'hc0
`define MSAF_CRC_POLY  32'h04c11db7
`define MSAF_CRC_INIT  32'hffffffff
`define MSAF_IMR_RESET 8'h00
`define MSAF_DA_BITS   48

`endif

// [msaf_pkg.sv]
package msaf_pkg;

  typedef logic [4:0] msaf_addr_t;
  typedef logic [7:0] msaf_byte_t;

  typedef enum logic [2:0]
  {
    MSAF_IDLE = 3'b001,
    MSAF_ADDR = 3'b010,
    MSAF_DONE = 3'b100
  } msaf_flt_t;

endpackage

// [msaf_top.sv]
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "msaf_defines.svh"
// Operation
// - A status flag in bits 0 to 6 clears only when software writes one to its bit.
// - Interrupt stays high while any unmasked status flag remains set.
// - Bit 0 marks a good receive; bit 1 marks a good transmit.
// - Bit 2 marks CRC, alignment, overrun or missed receive errors.
// - Bit 3 marks excessive collisions or transmit underrun.
// - Bit 4 marks receive ring exhausted at the boundary pointer.
// - Bit 5 sets when any tally counter top bit becomes set.
// - Bit 6 marks completion of a host-side copy transfer.
// - Bit 7 never interrupts, ignores writes, resets high, follows stop/overflow.
// - Three 8-bit tallies count alignment, CRC and missed packet events.
// - Each tally saturates at 192.
// - Reading a tally returns it and resets it to zero.
// - Retry count shows collisions this attempt in low four bits.
// - Excessive collisions set the abort flag and leave the count zero.
// - Setting the transmit go bit clears the retry count; a collision in the same cycle adds one to the old count instead.
// - Loopback readout holds the last 8 sent bytes; each read advances, except when a byte is sent in the same cycle, which moves it to the oldest.
// - Six station address bytes compare against each non-multicast destination address.
// - Destination address runs through the CRC; top 6 bits latch as index.
// - Index selects one of 64 filter bits; multicast accepted if set.
// - Filter bit n sits in hash register n/8 at bit n%8.
// - Interrupt only for masked-in flags; mask resets to all zeros.
module msaf_top
(
  input  wire logic               CLK_SYS,
  input  wire logic               RSTN,
  input  wire msaf_pkg::msaf_addr_t ADDR,
  input  wire msaf_pkg::msaf_byte_t WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output logic [7:0]              RDATA,
  output logic                    IRQ,
  input  wire logic               EV_RX_GOOD,
  input  wire logic               EV_TX_GOOD,
  input  wire logic               EV_RX_CRC,
  input  wire logic               EV_RX_ALIGN,
  input  wire logic               EV_RX_OVERRUN,
  input  wire logic               EV_RX_MISSED,
  input  wire logic               EV_TX_EXCESS_COL,
  input  wire logic               EV_TX_UNDERRUN,
  input  wire logic               EV_RING_FULL,
  input  wire logic               EV_COPY_DONE,
  input  wire logic               RING_OVERFLOW,
  input  wire logic               EV_COLLISION,
  input  wire logic               TX_BYTE_VALID,
  input  wire msaf_pkg::msaf_byte_t TX_BYTE,
  input  wire logic               RX_DA_START,
  input  wire logic               RX_DA_BIT_VALID,
  input  wire logic               RX_DA_BIT,
  input  wire logic               RX_DA_MULTICAST,
  output logic                    ADDR_DONE,
  output logic                    ADDR_ACCEPT,
  output logic [5:0]              HASH_INDEX,
  output logic                    TX_GO,
  output logic                    LOOPBACK_MODE
);
  import msaf_pkg::*;

  typedef struct packed
  {
    logic [7:0]       interrupt_status;
    logic [7:0]       interrupt_mask_register;
    logic [2:0][7:0]  tally;
    logic [3:0]       retry;
    logic             abort;
    logic             stopped;
    logic             loop;
    logic             txgo;
    logic [7:0][7:0]  lbuf;
    logic [2:0]       lwr;
    logic [2:0]       lrd;
    logic [5:0][7:0]  station;
    logic [7:0][7:0]  hash;
    logic [31:0]      crc;
    logic [5:0]       bitcnt;
    logic [47:0]      da;
    msaf_flt_t        flt;
    logic [5:0]       hidx;
    logic             accept;
    logic             done;
    logic [7:0]       rdata;
    logic             irq;
  } msaf_state_t;

  msaf_state_t s_q;
  msaf_state_t s_d;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
    crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? `MSAF_CRC_POLY : 32'h0);
  endfunction

  function automatic logic [7:0] tally_next(input logic [7:0] v, input logic ev,
                                             input logic clr);
    logic [7:0] n;
    n = clr ? 8'h00 : v;
    if (ev && (n != `MSAF_TALLY_MAX))
      n = n + 8'h01;
    tally_next = n;
  endfunction

  logic       wr_isr;
  logic       rd_tally_fae;
  logic       rd_tally_crc;
  logic       rd_tally_mis;
  logic [2:0] tally_ev;
  logic [7:0] ev_bits;
  logic       cmd_start;

  always_comb
  begin
    wr_isr       = WR && (ADDR == `MSAF_ADDR_ISR);
    rd_tally_fae = RD && (ADDR == `MSAF_ADDR_TALLY_FAE);
    rd_tally_crc = RD && (ADDR == `MSAF_ADDR_TALLY_CRC);
    rd_tally_mis = RD && (ADDR == `MSAF_ADDR_TALLY_MIS);
    tally_ev     = {EV_RX_MISSED, EV_RX_CRC, EV_RX_ALIGN};
    cmd_start    = WR && (ADDR == `MSAF_ADDR_CMD) && WDATA[`MSAF_CMD_START];
  end

  always_comb
  begin
    s_d = s_q;

    // Tallies: a clear on read in the same cycle as an event keeps the event
    s_d.tally[0] = tally_next(s_q.tally[0], tally_ev[0], rd_tally_fae);
    s_d.tally[1] = tally_next(s_q.tally[1], tally_ev[1], rd_tally_crc);
    s_d.tally[2] = tally_next(s_q.tally[2], tally_ev[2], rd_tally_mis);

    ev_bits = 8'h00;
    ev_bits[`MSAF_ISR_PRX] = EV_RX_GOOD;
    ev_bits[`MSAF_ISR_PTX] = EV_TX_GOOD;
    ev_bits[`MSAF_ISR_RXE] = EV_RX_CRC | EV_RX_ALIGN | EV_RX_OVERRUN
                             | EV_RX_MISSED;
    ev_bits[`MSAF_ISR_TXE] = EV_TX_EXCESS_COL | EV_TX_UNDERRUN;
    ev_bits[`MSAF_ISR_OVW] = EV_RING_FULL;
    ev_bits[`MSAF_ISR_CNT] = (s_d.tally[0][7] & ~s_q.tally[0][7])
                           | (s_d.tally[1][7] & ~s_q.tally[1][7])
                           | (s_d.tally[2][7] & ~s_q.tally[2][7]);
    ev_bits[`MSAF_ISR_RDC] = EV_COPY_DONE;

    // Set wins over a write-one clear arriving in the same cycle
    s_d.interrupt_status[6:0] = (s_q.interrupt_status[6:0] & ~(wr_isr ? WDATA[6:0] : 7'h00))
                 | ev_bits[6:0];

    // Command register: stop/start and transmit go
    s_d.txgo = 1'b0;
    if (WR && (ADDR == `MSAF_ADDR_CMD))
    begin
      if (WDATA[`MSAF_CMD_STOP])
        s_d.stopped = 1'b1;
      if (WDATA[`MSAF_CMD_START])
        s_d.stopped = 1'b0;
      s_d.loop = WDATA[`MSAF_CMD_LOOP];
      if (WDATA[`MSAF_CMD_TXGO])
      begin
        s_d.txgo  = 1'b1;
        s_d.retry = 4'h0;
        s_d.abort = 1'b0;
      end
    end
    if (cmd_start && !WDATA[`MSAF_CMD_STOP])
      s_d.stopped = 1'b0;
    s_d.interrupt_status[`MSAF_ISR_RST] = s_d.stopped | RING_OVERFLOW;

    if (WR && (ADDR == `MSAF_ADDR_IMR))
      s_d.interrupt_mask_register = {1'b0, WDATA[6:0]};

    // Collision counting; excessive collisions abort with a zero count
    if (EV_TX_EXCESS_COL)
    begin
      s_d.retry = 4'h0;
      s_d.abort = 1'b1;
    end
    else if (EV_COLLISION && (s_q.retry != 4'hf))
      s_d.retry = s_q.retry + 4'h1;

    if (WR && (ADDR[4:3] == 2'b10) && (ADDR[2:0] < 3'd6))
      s_d.station[ADDR[2:0]] = WDATA;
    if (WR && (ADDR[4:3] == 2'b11))
      s_d.hash[ADDR[2:0]] = WDATA;

    // Loopback ring keeps the last 8 bytes sent
    if (TX_BYTE_VALID)
    begin
      s_d.lbuf[s_q.lwr] = TX_BYTE;
      s_d.lwr = s_q.lwr + 3'd1;
      s_d.lrd = s_q.lwr + 3'd1;
    end
    else if (RD && (ADDR == `MSAF_ADDR_LOOPBACK))
      s_d.lrd = s_q.lrd + 3'd1;

    // Destination address filter
    s_d.done = 1'b0;
    case (s_q.flt)
      MSAF_IDLE:
      begin
        if (RX_DA_START)
        begin
          s_d.crc    = `MSAF_CRC_INIT;
          s_d.bitcnt = 6'd0;
          s_d.flt    = MSAF_ADDR;
        end
      end
      MSAF_ADDR:
      begin
        if (RX_DA_BIT_VALID)
        begin
          s_d.crc    = crc_step(s_q.crc, RX_DA_BIT);
          s_d.da     = {RX_DA_BIT, s_q.da[47:1]};
          s_d.bitcnt = s_q.bitcnt + 6'd1;
          if (s_q.bitcnt == 6'(`MSAF_DA_BITS - 1))
            s_d.flt = MSAF_DONE;
        end
      end
      MSAF_DONE:
      begin
        s_d.hidx = s_q.crc[31:26];
        s_d.accept = RX_DA_MULTICAST ? s_q.hash[s_q.crc[31:29]][s_q.crc[28:26]]
                                     : (s_q.da == s_q.station);
        s_d.done = 1'b1;
        s_d.flt  = MSAF_IDLE;
      end
      default: s_d.flt = MSAF_IDLE;
    endcase

    // Read data, valid only in the cycle after the strobe
    s_d.rdata = 8'h00;
    if (RD)
    begin
      case (ADDR)
        `MSAF_ADDR_ISR:       s_d.rdata = s_q.interrupt_status;
        `MSAF_ADDR_IMR:       s_d.rdata = s_q.interrupt_mask_register;
        `MSAF_ADDR_TALLY_FAE: s_d.rdata = s_q.tally[0];
        `MSAF_ADDR_TALLY_CRC: s_d.rdata = s_q.tally[1];
        `MSAF_ADDR_TALLY_MIS: s_d.rdata = s_q.tally[2];
        `MSAF_ADDR_RETRY:     s_d.rdata = {4'h0, s_q.retry};
        `MSAF_ADDR_LOOPBACK:  s_d.rdata = s_q.lbuf[s_q.lrd];
        `MSAF_ADDR_CMD:       s_d.rdata = {4'h0, s_q.loop, 1'b0, ~s_q.stopped, s_q.stopped};
        `MSAF_ADDR_TSR:       s_d.rdata = {4'h0, s_q.abort, 3'h0};
        default:
        begin
          if (ADDR[4:3] == 2'b10 && ADDR[2:0] < 3'd6)
            s_d.rdata = s_q.station[ADDR[2:0]];
          else if (ADDR[4:3] == 2'b11)
            s_d.rdata = s_q.hash[ADDR[2:0]];
          else
            s_d.rdata = 8'h00;
        end
      endcase
    end

    // Registered: flag and mask both taken from this cycle's next values
    s_d.irq = |(s_d.interrupt_status[6:0] & s_d.interrupt_mask_register[6:0]);
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      s_q         <= '0;
      s_q.interrupt_status     <= 8'h80;
      s_q.interrupt_mask_register     <= `MSAF_IMR_RESET;
      s_q.stopped <= 1'b1;
      s_q.flt     <= MSAF_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign RDATA         = s_q.rdata;
  assign IRQ           = s_q.irq;
  assign ADDR_DONE     = s_q.done;
  assign ADDR_ACCEPT   = s_q.accept;
  assign HASH_INDEX    = s_q.hidx;
  assign TX_GO         = s_q.txgo;
  assign LOOPBACK_MODE = s_q.loop;
endmodule

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  import msaf_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ovf = 1'b0, txv = 1'b0;
  logic        go = 1'b0, mc = 1'b0, irq, st, bv, db, done, acc, txgo, lpm;
  msaf_addr_t  addr = 5'h00;
  msaf_byte_t  wdata = 8'h00, txb = 8'h00;
  logic [10:0] ev = 11'h000;
  logic [7:0]  rdata;
  logic [5:0]  hidx, h;
  logic [47:0] da = 48'h0, sta = 48'h665544332211;
  int          eb[10] = '{0, 1, 2, 2, 2, 2, 3, 3, 4, 6};
  int          num_errors = 0, n_checks = 0;
  msaf_top dut (.CLK_SYS(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IRQ(irq), .EV_RX_GOOD(ev[0]), .EV_TX_GOOD(ev[1]), .EV_RX_CRC(ev[2]),
    .EV_RX_ALIGN(ev[3]), .EV_RX_OVERRUN(ev[4]), .EV_RX_MISSED(ev[5]),
    .EV_TX_EXCESS_COL(ev[6]), .EV_TX_UNDERRUN(ev[7]), .EV_RING_FULL(ev[8]),
    .EV_COPY_DONE(ev[9]), .RING_OVERFLOW(ovf), .EV_COLLISION(ev[10]), .TX_BYTE_VALID(txv),
    .TX_BYTE(txb), .RX_DA_START(st), .RX_DA_BIT_VALID(bv), .RX_DA_BIT(db),
    .RX_DA_MULTICAST(mc), .ADDR_DONE(done), .ADDR_ACCEPT(acc), .HASH_INDEX(hidx),
    .TX_GO(txgo), .LOOPBACK_MODE(lpm));
  msaf_da_src u_src (.clk(clk), .rst_n(rstn), .go(go), .da(da), .start(st),
    .bit_valid(bv), .da_bit(db));
  initial
    forever #20 clk = ~clk;
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr8(input msaf_addr_t a, input msaf_byte_t d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rc(input msaf_addr_t a, input msaf_byte_t e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic pulse(input int i, input int n);
    repeat (n)
    begin
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
    end
  endtask
  task automatic send(input logic [47:0] d, input logic m);
    int t;
    @(posedge clk);
    da <= d;
    mc <= m;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 80)
    begin
      @(posedge clk);
      #1;
      t++;
    end
    if (t == 80)
    begin
      num_errors++;
      $display("Error at %0t: address filter never finished", $time);
    end
  endtask
  function automatic logic [5:0] hash6(input logic [47:0] d);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int b = 0; b < 48; b++)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[b]) ? 32'h04c11db7 : 32'h00000000);
    return c[31:26];
  endfunction
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rc(5'h00, 8'h80);
    rc(5'h01, 8'h00);
    wr8(5'h00, 8'hff);
    for (int i = 0; i < 10; i++)
    begin
      pulse(i, 1);
      wr8(5'h01, 8'h01 << eb[i]);
      chk(irq, 8'h01);
      rc(5'h00, 8'h80 | (8'h01 << eb[i]));
      wr8(5'h00, 8'h00);
      chk(irq, 8'h01);
      wr8(5'h00, 8'h01 << eb[i]);
      chk(irq, 8'h00);
    end
    pulse(0, 1);
    pulse(1, 1);
    wr8(5'h01, 8'h03);
    wr8(5'h00, 8'h01);
    chk(irq, 8'h01);
    wr8(5'h00, 8'h02);
    chk(irq, 8'h00);
    wr8(5'h01, 8'h00);
    for (int k = 2; k < 5; k++)
      rc(msaf_addr_t'(k), 8'h01);
    rc(5'h02, 8'h00);
    pulse(3, 200);
    rc(5'h00, 8'ha4);
    rc(5'h02, 8'hc0);
    rc(5'h02, 8'h00);
    $display("test status and tallies done");
    wr8(5'h07, 8'h02);
    wr8(5'h00, 8'hff);
    rc(5'h00, 8'h00);
    @(posedge clk);
    ovf <= 1'b1;
    rc(5'h00, 8'h80);
    @(posedge clk);
    ovf <= 1'b0;
    wr8(5'h01, 8'h80);
    chk(irq, 8'h00);
    rc(5'h00, 8'h00);
    pulse(10, 3);
    rc(5'h05, 8'h03);
    wr8(5'h07, 8'h04);
    chk(txgo, 8'h01);
    rc(5'h05, 8'h00);
    pulse(10, 2);
    pulse(6, 1);
    rc(5'h05, 8'h00);
    rc(5'h08, 8'h08);
    $display("test command and retry done");
    wr8(5'h07, 8'h08);
    chk(lpm, 8'h01);
    for (int j = 0; j < 10; j++)
    begin
      @(posedge clk);
      txv <= 1'b1;
      txb <= 8'h30 + j[7:0];
      @(posedge clk);
      txv <= 1'b0;
    end
    for (int j = 2; j < 10; j++)
      rc(5'h06, 8'h30 + j[7:0]);
    $display("test loopback done");
    for (int k = 0; k < 8; k++)
      wr8(msaf_addr_t'(24 + k), 8'h00);
    for (int k = 0; k < 6; k++)
      wr8(msaf_addr_t'(16 + k), sta[8 * k +: 8]);
    send(sta, 1'b0);
    chk(acc, 8'h01);
    send(sta ^ 48'h010000000000, 1'b0);
    chk(acc, 8'h00);
    h = hash6(48'h0000000000a1);
    send(48'h0000000000a1, 1'b1);
    chk(hidx, h);
    chk(acc, 8'h00);
    wr8(msaf_addr_t'(24 + h[5:3]), 8'h01 << h[2:0]);
    send(48'h0000000000a1, 1'b1);
    chk(acc, 8'h01);
    $display("test address filter done");
    finish_test();
  end
  initial
  begin
    #400000;
    num_errors++;
    finish_test();
  end
endmodule
